// File: hdl/tsrs_pkg.sv
// Shared constants and types for the thermal supervisor register set
package tsrs_pkg;

  // ------------------------------------------------------------
  // Register pointer codes
  // ------------------------------------------------------------
  localparam logic [7:0] TSRS_PTR_TEMP = 8'h00;
  localparam logic [7:0] TSRS_PTR_CFG = 8'h01;
  localparam logic [7:0] TSRS_PTR_HYST = 8'h02;
  localparam logic [7:0] TSRS_PTR_SET = 8'h03;

  // ------------------------------------------------------------
  // Values after reset
  // ------------------------------------------------------------
  localparam logic [8:0] TSRS_TEMP_RESET = 9'h000;
  localparam logic [8:0] TSRS_HYST_RESET = 9'h096;
  localparam logic [8:0] TSRS_SET_RESET = 9'h0A0;
  localparam logic [7:0] TSRS_CFG_RESET = 8'h00;
  localparam logic [7:0] TSRS_PTR_RESET = 8'h00;

  // ------------------------------------------------------------
  // Configuration bit positions
  // ------------------------------------------------------------
  localparam int TSRS_CFG_FLAG = 7;
  localparam int TSRS_CFG_MASK = 6;
  localparam int TSRS_CFG_ZONE = 5;
  localparam int TSRS_CFG_DEPTH_HI = 4;
  localparam int TSRS_CFG_DEPTH_LO = 3;
  localparam int TSRS_CFG_POL = 2;
  localparam int TSRS_CFG_MODE = 1;
  localparam int TSRS_CFG_PDN = 0;

  // Position of values in the 16-bit serial word
  localparam int TSRS_VAL_LSB = 7;
  localparam int TSRS_BYTE_LSB = 8;

  // ------------------------------------------------------------
  // Filter depths in conversions
  // ------------------------------------------------------------
  localparam logic [2:0] TSRS_DEPTH_1 = 3'h1;
  localparam logic [2:0] TSRS_DEPTH_2 = 3'h2;
  localparam logic [2:0] TSRS_DEPTH_4 = 3'h4;
  localparam logic [2:0] TSRS_DEPTH_6 = 3'h6;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    TSRS_ARM_OVER = 2'b01,
    TSRS_ARM_UNDER = 2'b10
  } tsrs_arm_t;

  typedef struct packed {
    logic ptr_wr;
    logic [7:0] ptr;
    logic reg_wr;
    logic [15:0] wdata;
    logic reg_rd;
  } tsrs_host_req_t;

  typedef struct packed {
    logic [8:0] temp;
    logic [7:0] cfg;
    logic [8:0] hyst;
    logic [8:0] setp;
    logic [7:0] ptr;
    tsrs_arm_t arm;
    logic cmp_alert;
    logic int_alert;
    logic [15:0] rdata;
    logic rd_valid;
    logic alert_oe;
  } tsrs_state_t;

  typedef struct packed {
    logic [2:0] over_cnt;
    logic [2:0] under_cnt;
    logic over_q;
    logic under_q;
  } tsrs_filt_t;

  localparam tsrs_state_t TSRS_STATE_RESET = '{
    temp: TSRS_TEMP_RESET, cfg: TSRS_CFG_RESET, hyst: TSRS_HYST_RESET,
    setp: TSRS_SET_RESET, ptr: TSRS_PTR_RESET, arm: TSRS_ARM_OVER,
    cmp_alert: 1'b0, int_alert: 1'b0, rdata: 16'h0000, rd_valid: 1'b0,
    alert_oe: 1'b0};

  localparam tsrs_filt_t TSRS_FILT_RESET = '{
    over_cnt: 3'h0, under_cnt: 3'h0, over_q: 1'b0, under_q: 1'b0};

endpackage

// File: hdl/tsrs_filter.sv
// Consecutive-conversion filter for over and under threshold events
`timescale 1ns/1ps
module tsrs_filter
  import tsrs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Conversion result and thresholds
  input wire logic conv,
  input wire logic [8:0] result,
  input wire logic [8:0] hyst,
  input wire logic [8:0] setp,
  input wire logic [1:0] depth_code,
  // Qualified events, one-cycle pulses
  output logic over_q,
  output logic under_q
);

  tsrs_filt_t f;
  tsrs_filt_t next_f;
  logic over;
  logic under;
  logic [2:0] depth;

  // ------------------------------------------------------------
  // Compare and count
  // ------------------------------------------------------------
  // Values are two's complement, so compare signed
  always_comb begin
    over = $signed(result) > $signed(setp);
    under = $signed(result) < $signed(hyst);
    case (depth_code)
      2'b00: depth = TSRS_DEPTH_1;
      2'b01: depth = TSRS_DEPTH_2;
      2'b10: depth = TSRS_DEPTH_4;
      2'b11: depth = TSRS_DEPTH_6;
      default: depth = TSRS_DEPTH_1;
    endcase
    next_f = f;
    next_f.over_q = 1'b0;
    next_f.under_q = 1'b0;
    if (conv) begin
      // Saturate at the deepest setting so a shallower one still qualifies
      next_f.over_cnt = over ? ((f.over_cnt == TSRS_DEPTH_6) ?
        TSRS_DEPTH_6 : f.over_cnt + 3'h1) : 3'h0;
      next_f.under_cnt = under ? ((f.under_cnt == TSRS_DEPTH_6) ?
        TSRS_DEPTH_6 : f.under_cnt + 3'h1) : 3'h0;
      next_f.over_q = over && (next_f.over_cnt >= depth);
      next_f.under_q = under && (next_f.under_cnt >= depth);
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      f <= TSRS_FILT_RESET;
    end else begin
      f <= next_f;
    end
  end

  assign over_q = f.over_q;
  assign under_q = f.under_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_depth_one_fires: assert property (
    @(posedge clk) disable iff (reset)
    conv && over && depth_code == 2'b00 |=> over_q)
    else $error("single-conversion depth did not qualify");

  a_no_early_event: assert property (
    @(posedge clk) disable iff (reset)
    conv && f.over_cnt == 3'h0 && depth_code != 2'b00 |=> !over_q)
    else $error("over event qualified before filter depth");

endmodule

// File: hdl/tsrs_regs.sv
// Register set of the thermal supervisor: pointer, registers, alert pin
//
// Behaviour
// - Pointer codes 0-3 pick the four registers
// - Temperature read in bits 15..7, rest zero
// - Temperature zero at reset, then last conversion
// - Thresholds reset to 75 and 80 degrees
// - Configuration resets to all zeros
// - Bit 7 event flag, read only
// - Bit 6 mask releases alert pin
// - Bit 5 selects remote or local zone
// - Bits 4..3 set depth 1,2,4,6
// - Bit 2 sets alert polarity
// - Bit 1 picks interrupt or comparator mode
// - Bit 0 enters low-power shutdown
// - Qualified event sets the event flag; in interrupt mode only the armed one does
// - Configuration read clears event flag
// - Comparator alert holds until under hysteresis
// - Interrupt mode: read or shutdown clears
// - Events need consecutive qualifying conversions
`timescale 1ns/1ps
module tsrs_regs
  import tsrs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Access from the serial port engine
  input wire tsrs_host_req_t req,
  output logic [15:0] reg_rdata,
  output logic rd_valid,
  // Converter side
  input wire logic conv_done,
  input wire logic [8:0] conv_result,
  output logic zone_remote,
  output logic power_down,
  // Open-drain alert pin
  output logic alert_out,
  output logic alert_oe
);

  tsrs_state_t s;
  tsrs_state_t next_s;
  logic conv;
  logic ev_over;
  logic ev_under;
  logic asserted;
  logic [7:0] wcfg;

  // Conversions are frozen while powered down
  assign conv = conv_done && !s.cfg[TSRS_CFG_PDN];

  // ------------------------------------------------------------
  // Event filter
  // ------------------------------------------------------------
  // Consecutive qualifying conversions before an event counts
  tsrs_filter u_filter (
    .clk(clk),
    .reset(reset),
    .conv(conv),
    .result(conv_result),
    .hyst(s.hyst),
    .setp(s.setp),
    .depth_code(s.cfg[TSRS_CFG_DEPTH_HI:TSRS_CFG_DEPTH_LO]),
    .over_q(ev_over),
    .under_q(ev_under)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  // Clears are applied first so a same-cycle event still sets the flag
  always_comb begin
    next_s = s;
    next_s.rd_valid = 1'b0;
    wcfg = req.wdata[15:TSRS_BYTE_LSB];
    if (req.ptr_wr) begin
      next_s.ptr = req.ptr;
    end
    if (req.reg_wr) begin
      case (s.ptr)
        TSRS_PTR_CFG: begin
          next_s.cfg[6:0] = wcfg[6:0];
          if (wcfg[TSRS_CFG_MODE] && !s.cfg[TSRS_CFG_MODE]) begin
            next_s.arm = TSRS_ARM_OVER;
          end
          // Entering shutdown drops a pending interrupt
          if (wcfg[TSRS_CFG_PDN] && !s.cfg[TSRS_CFG_PDN] &&
              s.cfg[TSRS_CFG_MODE]) begin
            next_s.cfg[TSRS_CFG_FLAG] = 1'b0;
            next_s.int_alert = 1'b0;
          end
        end
        TSRS_PTR_HYST: next_s.hyst = req.wdata[15:TSRS_VAL_LSB];
        TSRS_PTR_SET: next_s.setp = req.wdata[15:TSRS_VAL_LSB];
        default: ;
      endcase
    end
    if (req.reg_rd) begin
      next_s.rd_valid = 1'b1;
      case (s.ptr)
        TSRS_PTR_TEMP: next_s.rdata = {s.temp, 7'h00};
        TSRS_PTR_CFG: next_s.rdata = {s.cfg, 8'h00};
        TSRS_PTR_HYST: next_s.rdata = {s.hyst, 7'h00};
        TSRS_PTR_SET: next_s.rdata = {s.setp, 7'h00};
        default: next_s.rdata = 16'h0000;
      endcase
      if (s.ptr == TSRS_PTR_CFG) begin
        next_s.cfg[TSRS_CFG_FLAG] = 1'b0;
      end
      if (s.cfg[TSRS_CFG_MODE]) begin
        next_s.cfg[TSRS_CFG_FLAG] = 1'b0;
        next_s.int_alert = 1'b0;
      end
    end
    if (conv) begin
      next_s.temp = conv_result;
    end
    // Comparator alert follows qualified events with hysteresis
    if (ev_over) begin
      next_s.cmp_alert = 1'b1;
    end else if (ev_under) begin
      next_s.cmp_alert = 1'b0;
    end
    if (!s.cfg[TSRS_CFG_MODE]) begin
      if (ev_over || ev_under) begin
        next_s.cfg[TSRS_CFG_FLAG] = 1'b1;
      end
    end else begin
      // Alternate over and under so one excursion raises one interrupt
      case (s.arm)
        TSRS_ARM_OVER: begin
          if (ev_over) begin
            next_s.cfg[TSRS_CFG_FLAG] = 1'b1;
            next_s.int_alert = 1'b1;
            next_s.arm = TSRS_ARM_UNDER;
          end
        end
        TSRS_ARM_UNDER: begin
          if (ev_under) begin
            next_s.cfg[TSRS_CFG_FLAG] = 1'b1;
            next_s.int_alert = 1'b1;
            next_s.arm = TSRS_ARM_OVER;
          end
        end
        default: next_s.arm = TSRS_ARM_OVER;
      endcase
    end
    asserted = next_s.cfg[TSRS_CFG_MODE] ? next_s.int_alert :
      next_s.cmp_alert;
    // Active high means releasing the pin; the mask always releases it
    next_s.alert_oe = !next_s.cfg[TSRS_CFG_MASK] &&
      (next_s.cfg[TSRS_CFG_POL] ? !asserted : asserted);
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      s <= TSRS_STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign reg_rdata = s.rdata;
  assign rd_valid = s.rd_valid;
  assign zone_remote = s.cfg[TSRS_CFG_ZONE];
  assign power_down = s.cfg[TSRS_CFG_PDN];
  // Open drain only ever pulls low
  assign alert_out = 1'b0;
  assign alert_oe = s.alert_oe;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);

  a_reset_thresholds: assert property ($fell(reset) |->
    s.hyst == TSRS_HYST_RESET && s.setp == TSRS_SET_RESET &&
    s.cfg == TSRS_CFG_RESET && s.temp == TSRS_TEMP_RESET)
    else $error("register values wrong after reset");

  a_cfg_read_clears: assert property (
    req.reg_rd && s.ptr == TSRS_PTR_CFG && !ev_over && !ev_under
    |=> !s.cfg[TSRS_CFG_FLAG])
    else $error("configuration read left flag set");

  a_flag_write_ignored: assert property (
    req.reg_wr && !req.reg_rd && s.ptr == TSRS_PTR_CFG &&
    s.cfg[TSRS_CFG_FLAG] && !req.wdata[TSRS_BYTE_LSB]
    |=> s.cfg[TSRS_CFG_FLAG])
    else $error("write changed event flag");

  a_event_sets_flag: assert property (
    ev_over && !s.cfg[TSRS_CFG_MODE] |=> s.cfg[TSRS_CFG_FLAG])
    else $error("qualified event did not set flag");

  a_mask_releases_pin: assert property (
    s.cfg[TSRS_CFG_MASK] |-> !alert_oe)
    else $error("masked alert still drives pin");

  a_cmp_alert_holds: assert property (
    !s.cfg[TSRS_CFG_MODE] && s.cmp_alert && !ev_under |=> s.cmp_alert)
    else $error("comparator alert dropped without under event");

  a_int_read_clears: assert property (
    s.cfg[TSRS_CFG_MODE] && req.reg_rd && !ev_over && !ev_under
    |=> !s.int_alert)
    else $error("read did not clear interrupt alert");

  a_low_polarity_drive: assert property (
    !s.cfg[TSRS_CFG_MASK] && !s.cfg[TSRS_CFG_POL] &&
    !s.cfg[TSRS_CFG_MODE] |-> alert_oe == s.cmp_alert)
    else $error("active-low alert pin mismatch");

  a_temp_load: assert property (conv |=> s.temp == $past(conv_result))
    else $error("temperature not loaded from conversion");

  a_temp_write_ignored: assert property (
    req.reg_wr && !conv && s.ptr == TSRS_PTR_TEMP |=> $stable(s.temp))
    else $error("write changed temperature");

  a_ptr_kept: assert property (!req.ptr_wr |=> $stable(s.ptr))
    else $error("pointer changed without pointer write");

  c_over_event: cover property (ev_over ##[1:20] s.cfg[TSRS_CFG_FLAG]);
  c_int_cleared: cover property (s.int_alert ##1 req.reg_rd ##1
    !s.int_alert);
  c_masked_alert: cover property (s.cmp_alert && s.cfg[TSRS_CFG_MASK]);

endmodule

// File: verification/tsrs_host_model.sv
// Host controller model issuing register accesses to the register set
`timescale 1ns/1ps
module tsrs_host_model
  import tsrs_pkg::*;
(
  // Clock
  input wire logic clk,
  // Requests towards the register set
  output tsrs_host_req_t req
);
  // ----
  // Access sequencing
  // ----
  initial req = '0;

  // Pointer cycle, then access; pointer resent only when asked
  task automatic xfer(input bit pw, input logic [7:0] p, input bit wr,
                      input logic [15:0] w, input bit rd);
    if (pw) begin
      @(posedge clk);
      req <= '{1'b1, p, 1'b0, 16'h0000, 1'b0};
    end
    @(posedge clk);
    req <= '{1'b0, p, wr, w, rd};
    @(posedge clk);
    // Released fields show junk, never the old request
    req <= '{1'b0, ~p, 1'b0, ~w, 1'b0};
    #1;
  endtask
endmodule

// File: verification/tsrs_regs_tb.sv
// Self-checking bench for the thermal supervisor register set
`timescale 1ns/1ps
module tsrs_regs_tb
  import tsrs_pkg::*;
;
  // ----
  // Signals, design and host
  // ----
  logic clk;
  logic reset;
  logic conv_done;
  logic [8:0] conv_result;
  tsrs_host_req_t req;
  logic [15:0] reg_rdata;
  logic rd_valid;
  logic zone_remote;
  logic power_down;
  logic alert_out;
  logic alert_oe;
  logic [15:0] exp_q[$];
  int n_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int seed = 32'h8716;
  logic [8:0] rv;
  localparam logic [8:0] HOT = 9'h0B0;
  localparam logic [8:0] COLD = 9'h050;
  localparam logic [2:0] DEPTH [4] = '{3'h1, 3'h2, 3'h4, 3'h6};

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  tsrs_regs uut (.clk(clk), .reset(reset), .req(req),
    .reg_rdata(reg_rdata), .rd_valid(rd_valid), .conv_done(conv_done),
    .conv_result(conv_result), .zone_remote(zone_remote),
    .power_down(power_down), .alert_out(alert_out), .alert_oe(alert_oe));
  tsrs_host_model host (.clk(clk), .req(req));

  // ----
  // Checking and stimulus tasks
  // ----
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic al(input logic e);
    check({15'h0000, alert_oe}, {15'h0000, e});
  endtask

  task automatic wr(input logic [7:0] p, input logic [15:0] w);
    host.xfer(1'b1, p, 1'b1, w, 1'b0);
  endtask

  // Expectation noted before the access goes out
  task automatic rd(input logic [7:0] p, input logic [15:0] e);
    exp_q.push_back(e);
    host.xfer(1'b1, p, 1'b0, 16'h0000, 1'b1);
  endtask

  // Alert settles one edge after the edge that samples conv_done
  task automatic conv(input logic [8:0] v);
    @(posedge clk);
    conv_done <= 1'b1;
    conv_result <= v;
    @(posedge clk);
    conv_done <= 1'b0;
    conv_result <= ~v;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic wrap_up();
    if (n_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Read data watcher takes the oldest note
  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() > 0) check(reg_rdata, exp_q.pop_front());
      else check(reg_rdata, 16'hXXXX);
    end
  end

  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  initial begin
    reset = 1'b1;
    conv_done = 1'b0;
    conv_result = 9'h000;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    rd(TSRS_PTR_TEMP, 16'h0000);
    rd(TSRS_PTR_CFG, 16'h0000);
    rd(TSRS_PTR_HYST, {9'h096, 7'h00});
    rd(TSRS_PTR_SET, {9'h0A0, 7'h00});
    exp_q.push_back({9'h0A0, 7'h00});
    host.xfer(1'b0, TSRS_PTR_TEMP, 1'b0, 16'h0000, 1'b1);
    rd(8'h04, 16'h0000);
    check({15'h0000, alert_out}, 16'h0000);
    al(1'b0);
    wr(TSRS_PTR_TEMP, 16'hFF80);
    rd(TSRS_PTR_TEMP, 16'h0000);
    wr(TSRS_PTR_CFG, 16'hA100);
    rd(TSRS_PTR_CFG, 16'h2100);
    check({14'h0000, zone_remote, power_down}, 16'h0003);
    conv(HOT);
    rd(TSRS_PTR_TEMP, 16'h0000);
    wr(TSRS_PTR_CFG, 16'h0000);
    repeat (3) begin
      rv = 9'($random(seed));
      wr(TSRS_PTR_HYST, {rv, 7'h00});
      wr(TSRS_PTR_SET, {~rv, 7'h00});
      rd(TSRS_PTR_HYST, {rv, 7'h00});
      rd(TSRS_PTR_SET, {~rv, 7'h00});
    end
    wr(TSRS_PTR_HYST, {9'h096, 7'h00});
    wr(TSRS_PTR_SET, {9'h0A0, 7'h00});
    // Every filter depth: one short of depth keeps quiet
    for (int d = 0; d < 4; d++) begin
      wr(TSRS_PTR_CFG, {3'b000, 2'(d), 3'b000, 8'h00});
      for (int i = 1; i < DEPTH[d]; i++) begin
        conv(HOT);
        al(1'b0);
      end
      conv(HOT);
      al(1'b1);
      rd(TSRS_PTR_CFG, {3'b100, 2'(d), 3'b000, 8'h00});
      for (int i = 1; i < DEPTH[d]; i++) begin
        conv(COLD);
        al(1'b1);
      end
      conv(COLD);
      al(1'b0);
      rd(TSRS_PTR_CFG, {3'b100, 2'(d), 3'b000, 8'h00});
      rd(TSRS_PTR_CFG, {3'b000, 2'(d), 3'b000, 8'h00});
    end
    rd(TSRS_PTR_TEMP, {COLD, 7'h00});
    wr(TSRS_PTR_CFG, 16'h0400);
    al(1'b1);
    wr(TSRS_PTR_CFG, 16'h4400);
    al(1'b0);
    wr(TSRS_PTR_CFG, 16'h0000);
    conv(HOT);
    al(1'b1);
    wr(TSRS_PTR_CFG, 16'h4000);
    al(1'b0);
    wr(TSRS_PTR_CFG, 16'h0400);
    al(1'b0);
    wr(TSRS_PTR_CFG, 16'h0000);
    conv(COLD);
    al(1'b0);
    rd(TSRS_PTR_CFG, 16'h8000);
    // Interrupt mode: any read or shutdown entry clears
    wr(TSRS_PTR_CFG, 16'h0200);
    conv(HOT);
    al(1'b1);
    rd(TSRS_PTR_SET, {9'h0A0, 7'h00});
    al(1'b0);
    rd(TSRS_PTR_CFG, 16'h0200);
    conv(COLD);
    al(1'b1);
    wr(TSRS_PTR_CFG, 16'h0300);
    al(1'b0);
    check({14'h0000, zone_remote, power_down}, 16'h0001);
    rd(TSRS_PTR_CFG, 16'h0300);
    wr(TSRS_PTR_CFG, 16'h0000);
    repeat (3) begin
      rv = 9'($random(seed));
      conv(rv);
      rd(TSRS_PTR_TEMP, {rv, 7'h00});
    end
    repeat (4) @(posedge clk);
    check(16'(exp_q.size()), 16'h0000);
    wrap_up();
  end
endmodule
